// [design/dfa_regs.vh]
// register offsets, field positions and encodings of the full-address dma channel pair
`ifndef DFA_REGS_VH
`define DFA_REGS_VH

`define DFA_OFF_SRC_ADDR 12'h000
`define DFA_OFF_DST_ADDR 12'h004
`define DFA_OFF_XFER_CNT 12'h008
`define DFA_OFF_BLK_CNT 12'h00C
`define DFA_OFF_CTL_PRI 12'h010
`define DFA_OFF_CTL_SEC 12'h014

`define DFA_ADDR_TOP_BYTE 8'hFF
`define DFA_CTL_RESET 8'h00
`define DFA_PAD_CTL 24'h000000
`define DFA_PAD_CNT 16'h0000
`define DFA_RDATA_ZERO 32'h00000000

`define DFA_CNT_LAST 16'h0001
`define DFA_BSZ_LAST 8'h01
`define DFA_CNT_ONE 16'h0001
`define DFA_BSZ_ONE 8'h01
`define DFA_STEP_BYTE 24'h000001
`define DFA_STEP_WORD 24'h000002

`define DFA_BIT_ENABLE 7
`define DFA_BIT_SIZE 6
`define DFA_BIT_DIR 5
`define DFA_BIT_UPD 4
`define DFA_BIT_IE 3
`define DFA_BIT_AREA 3
`define DFA_BIT_FULL_HI 2
`define DFA_BIT_FULL_LO 1
`define DFA_BIT_BLOCK 0

`define DFA_SRC_AUTO_BURST 3'h0
`define DFA_SRC_AUTO_STEAL 3'h2
`define DFA_SRC_EXT_EDGE 3'h6
`define DFA_SRC_EXT_LEVEL 3'h7
`define DFA_SRC_TIMER_BIT 2

`endif

// [design/dfa_addr_step.v]
// one address updater: hold, increment or decrement by byte or word step
`timescale 1ns/10ps
`include "dfa_regs.vh"
module dfa_addr_step
(
    input wire [23:0] addr_i,
    input wire dir_i,
    input wire upd_en_i,
    input wire word_i,
    output wire [23:0] next_addr_o
);
    wire [23:0] step;
    assign step = word_i ? `DFA_STEP_WORD : `DFA_STEP_BYTE;
    // the top byte never moves, so the step wraps within 24 bits
    assign next_addr_o = !upd_en_i ? addr_i : (dir_i ? addr_i - step : addr_i + step);
endmodule

// [design/dfa_req_detect.v]
// external request pin conditioner: falling edge pulse and low level
`timescale 1ns/10ps
module dfa_req_detect
(
    input wire core_clk_i,
    input wire resetn_i,
    input wire external_request_pin_n_i,
    output wire fall_o,
    output wire low_o
);
    reg prev;
    always @(posedge core_clk_i)
    begin
        if (!resetn_i)
            prev <= 1'b1;
        else
            prev <= external_request_pin_n_i;
    end
    assign fall_o = prev & ~external_request_pin_n_i;
    assign low_o = ~external_request_pin_n_i;
endmodule

// [design/dfa_channel.v]
// full-address dma channel pair: apb registers, request decode and transfer sequencer
//
// Operation
// - A half holds source address, B half holds destination address, one channel.
// - Address registers are 32 bits; top byte ignores writes, reads all ones.
// - Address and count registers keep contents through reset and standby.
// - Normal mode: primary count is 16-bit transfer counter, ends at zero.
// - Block mode: upper count byte counts block, reloads from lower byte.
// - Block mode: block count decrements per block, transfer ends at zero.
// - Full address mode when primary control bits 2 and 1 both one.
// - Both control registers clear on reset and on standby entry.
// - Runs only with both enables; auto-request starts at once, else waits.
// - Channel enable clears itself at end; requests ignored while it is zero.
// - Channel enable sets only by reading it as zero, then writing one.
// - Clearing channel enable raises end interrupt when interrupt enable set.
// - Primary bit 6 selects byte or word per transfer.
// - Source address holds, increments or decrements by size per transfer.
// - Destination address follows same scheme using secondary bits 5 and 4.
// - Primary bit 0 selects normal or block transfer mode.
// - Non-maskable interrupt clears master enable; transfer resumes when set again.
// - Master enable sets only by reading it as zero, then writing one.
// - Secondary bit 6 stores and returns whatever is written.
// - Secondary bit 3 picks block area: zero destination, one source.
// - Normal mode sources: auto burst, auto steal, pin edge, pin level.
// - Block mode sources: timer compare A channels 0-3, or pin edge.
// - Cycle-steal releases bus per unit; burst holds unless higher master asks.
// - Block mode restores block-area address at end of each block.
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "dfa_regs.vh"
module dfa_channel
(
    input wire core_clk_i,
    input wire resetn_i,
    input wire standby_i,
    input wire nmi_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire external_request_pin_n_i,
    input wire [3:0] timer_match_i,
    input wire hp_req_i,
    input wire xfer_done_i,
    output reg xfer_req_o,
    output reg xfer_word_o,
    output reg [23:0] xfer_src_o,
    output reg [23:0] xfer_dst_o,
    output reg bus_hold_o,
    output reg transfer_end_interrupt_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_MOVE = 3'b010;
    localparam ST_GAP = 3'b100;

    reg [23:0] source_address;
    reg [23:0] destination_address;
    reg [15:0] transfer_or_block_size_count;
    reg [15:0] block_count;
    reg [7:0] channel_control_primary;
    reg [7:0] channel_control_secondary;
    reg [23:0] block_base;
    reg en_armed;
    reg men_armed;
    reg pending;
    reg in_block;
    reg end_flag;
    reg [2:0] state;

    wire [23:0] src_next;
    wire [23:0] dst_next;
    wire pin_fall;
    wire pin_low;

    // apb phases: a setup cycle loads the answer, the access edge commits it
    wire setup = psel_i & ~penable_i;
    wire access = psel_i & penable_i & pready_o;
    wire wr = access & pwrite_i;
    wire rd = access & ~pwrite_i;
    wire hit_src = paddr_i == `DFA_OFF_SRC_ADDR;
    wire hit_dst = paddr_i == `DFA_OFF_DST_ADDR;
    wire hit_cnt = paddr_i == `DFA_OFF_XFER_CNT;
    wire hit_blk = paddr_i == `DFA_OFF_BLK_CNT;
    wire hit_cpa = paddr_i == `DFA_OFF_CTL_PRI;
    wire hit_cpb = paddr_i == `DFA_OFF_CTL_SEC;
    wire mapped = hit_src | hit_dst | hit_cnt | hit_blk | hit_cpa | hit_cpb;

    wire channel_enable = channel_control_primary[`DFA_BIT_ENABLE];
    wire master_enable = channel_control_secondary[`DFA_BIT_ENABLE];
    wire word = channel_control_primary[`DFA_BIT_SIZE];
    wire full_mode = channel_control_primary[`DFA_BIT_FULL_HI] & channel_control_primary[`DFA_BIT_FULL_LO];
    wire block_mode = channel_control_primary[`DFA_BIT_BLOCK];
    wire src_is_area = channel_control_secondary[`DFA_BIT_AREA];
    wire [2:0] src_sel = channel_control_secondary[2:0];
    wire active = full_mode & channel_enable & master_enable;

    // activation decode; unusable codes never start anything
    wire auto_burst = ~block_mode & (src_sel == `DFA_SRC_AUTO_BURST);
    wire auto_steal = ~block_mode & (src_sel == `DFA_SRC_AUTO_STEAL);
    wire auto_req = auto_burst | auto_steal;
    wire ext_edge = (src_sel == `DFA_SRC_EXT_EDGE) & pin_fall;
    wire ext_level = ~block_mode & (src_sel == `DFA_SRC_EXT_LEVEL) & pin_low;
    wire timer_trig = block_mode & ~src_sel[`DFA_SRC_TIMER_BIT] & timer_match_i[src_sel[1:0]];
    wire trig = (ext_edge | ext_level | timer_trig) & full_mode & channel_enable;

    wire unit_done = state[1] & xfer_done_i;
    wire blk_last = transfer_or_block_size_count[15:8] == `DFA_BSZ_LAST;
    wire block_end = unit_done & block_mode & blk_last;
    wire finish = unit_done & (block_mode ? (blk_last & block_count == `DFA_CNT_LAST)
                                          : transfer_or_block_size_count == `DFA_CNT_LAST);
    wire start = state[0] & active & (auto_req | pending | in_block);
    wire keep_bus = (auto_burst | (block_mode & ~block_end)) & ~hp_req_i & active & ~finish;

    dfa_addr_step u_src_step
    (
        .addr_i(source_address),
        .dir_i(channel_control_primary[`DFA_BIT_DIR]),
        .upd_en_i(channel_control_primary[`DFA_BIT_UPD]),
        .word_i(word),
        .next_addr_o(src_next)
    );

    dfa_addr_step u_dst_step
    (
        .addr_i(destination_address),
        .dir_i(channel_control_secondary[`DFA_BIT_DIR]),
        .upd_en_i(channel_control_secondary[`DFA_BIT_UPD]),
        .word_i(word),
        .next_addr_o(dst_next)
    );

    dfa_req_detect u_pin
    (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .external_request_pin_n_i(external_request_pin_n_i),
        .fall_o(pin_fall),
        .low_o(pin_low)
    );

    // data registers have no reset branch: they keep their contents through reset and standby
    always @(posedge core_clk_i)
    begin
        if (wr & hit_src)
            source_address <= pwdata_i[23:0];
        else if (block_end & src_is_area)
            source_address <= block_base;
        else if (unit_done)
            source_address <= src_next;
        if (wr & hit_dst)
            destination_address <= pwdata_i[23:0];
        else if (block_end & ~src_is_area)
            destination_address <= block_base;
        else if (unit_done)
            destination_address <= dst_next;
        if (wr & hit_cnt)
            transfer_or_block_size_count <= pwdata_i[15:0];
        else if (unit_done & ~block_mode)
            transfer_or_block_size_count <= transfer_or_block_size_count - `DFA_CNT_ONE;
        else if (block_end)
            transfer_or_block_size_count[15:8] <= transfer_or_block_size_count[7:0];
        else if (unit_done)
            transfer_or_block_size_count[15:8] <= transfer_or_block_size_count[15:8] - `DFA_BSZ_ONE;
        if (wr & hit_blk)
            block_count <= pwdata_i[15:0];
        else if (block_end)
            block_count <= block_count - `DFA_CNT_ONE;
        if (start & block_mode & ~in_block)
            block_base <= src_is_area ? source_address : destination_address;
    end

    // control registers and the read-then-write arming of both enables
    always @(posedge core_clk_i)
    begin
        if (!resetn_i | standby_i)
        begin
            channel_control_primary <= `DFA_CTL_RESET;
            channel_control_secondary <= `DFA_CTL_RESET;
            en_armed <= 1'b0;
            men_armed <= 1'b0;
            end_flag <= 1'b0;
        end
        else
        begin
            if (rd & hit_cpa & ~channel_enable)
                en_armed <= 1'b1;
            else if (wr & hit_cpa)
                en_armed <= 1'b0;
            if (rd & hit_cpb & ~master_enable)
                men_armed <= 1'b1;
            else if (wr & hit_cpb)
                men_armed <= 1'b0;

            if (finish)
                channel_control_primary[`DFA_BIT_ENABLE] <= 1'b0;
            else if (wr & hit_cpa)
                channel_control_primary[`DFA_BIT_ENABLE] <= pwdata_i[`DFA_BIT_ENABLE] &
                                                            (channel_enable | en_armed);
            if (wr & hit_cpa)
                channel_control_primary[6:0] <= pwdata_i[6:0];

            // the interrupt wins over a software write of one
            if (nmi_i)
                channel_control_secondary[`DFA_BIT_ENABLE] <= 1'b0;
            else if (wr & hit_cpb)
                channel_control_secondary[`DFA_BIT_ENABLE] <= pwdata_i[`DFA_BIT_ENABLE] &
                                                              (master_enable | men_armed);
            if (wr & hit_cpb)
                channel_control_secondary[6:0] <= pwdata_i[6:0];

            // end stays flagged until software re-arms the channel; clearing the interrupt enable only masks the output
            if (finish | (wr & hit_cpa & channel_enable & ~pwdata_i[`DFA_BIT_ENABLE]))
                end_flag <= 1'b1;
            else if (channel_enable)
                end_flag <= 1'b0;
        end
    end

    // apb slave: zero wait states, error on unmapped addresses
    always @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= `DFA_RDATA_ZERO;
        end
        else
        begin
            pready_o <= setup;
            pslverr_o <= setup & ~mapped;
            if (setup)
            begin
                if (hit_src)
                    prdata_o <= {`DFA_ADDR_TOP_BYTE, source_address};
                else if (hit_dst)
                    prdata_o <= {`DFA_ADDR_TOP_BYTE, destination_address};
                else if (hit_cnt)
                    prdata_o <= {`DFA_PAD_CNT, transfer_or_block_size_count};
                else if (hit_blk)
                    prdata_o <= {`DFA_PAD_CNT, block_count};
                else if (hit_cpa)
                    prdata_o <= {`DFA_PAD_CTL, channel_control_primary};
                else if (hit_cpb)
                    prdata_o <= {`DFA_PAD_CTL, channel_control_secondary};
                else
                    prdata_o <= `DFA_RDATA_ZERO;
            end
        end
    end

    // transfer sequencer
    always @(posedge core_clk_i)
    begin
        if (!resetn_i | standby_i)
        begin
            state <= ST_IDLE;
            pending <= 1'b0;
            in_block <= 1'b0;
            xfer_req_o <= 1'b0;
            bus_hold_o <= 1'b0;
            transfer_end_interrupt_o <= 1'b0;
        end
        else
        begin
            transfer_end_interrupt_o <= end_flag & channel_control_primary[`DFA_BIT_IE];
            // a request arriving while the previous one is taken is kept
            if (trig)
                pending <= 1'b1;
            else if (start & ~in_block | ~channel_enable)
                pending <= 1'b0;
            if (finish | ~channel_enable)
                in_block <= 1'b0;
            else if (start & block_mode)
                in_block <= 1'b1;
            else if (block_end)
                in_block <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        state <= ST_MOVE;
                        xfer_req_o <= 1'b1;
                        bus_hold_o <= 1'b1;
                    end
                end
                ST_MOVE:
                begin
                    // a suspended unit still completes; the next one waits for both enables
                    if (unit_done)
                    begin
                        xfer_req_o <= keep_bus;
                        bus_hold_o <= keep_bus;
                        state <= keep_bus ? ST_MOVE : ST_GAP;
                    end
                end
                ST_GAP:
                begin
                    state <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                    xfer_req_o <= 1'b0;
                    bus_hold_o <= 1'b0;
                end
            endcase
        end
    end

    // address and size outputs are registered copies of what the next unit uses
    always @(posedge core_clk_i)
    begin
        if (!resetn_i)
            xfer_word_o <= 1'b0;
        else
            xfer_word_o <= word;
        xfer_src_o <= unit_done ? (block_end & src_is_area ? block_base : src_next) : source_address;
        xfer_dst_o <= unit_done ? (block_end & ~src_is_area ? block_base : dst_next) : destination_address;
    end
endmodule

// [tb/dfa_channel_properties.sv]
// port-level assertions for the full-address dma channel pair
`timescale 1ns/10ps
module dfa_channel_checker
(
    input wire core_clk_i,
    input wire resetn_i,
    input wire standby_i,
    input wire nmi_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire xfer_done_i,
    input wire xfer_req_o,
    input wire xfer_word_o,
    input wire [23:0] xfer_src_o,
    input wire [23:0] xfer_dst_o,
    input wire bus_hold_o,
    input wire transfer_end_interrupt_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_slverr_zero_data: assert property (pslverr_o |-> pready_o && prdata_o == 32'h00000000)
        else $error("error response outside access or with data");
    a_top_byte_ones: assert property (pready_o && !pwrite_i && paddr_i[11:3] == 9'h000 |-> prdata_o[31:24] == 8'hFF)
        else $error("address top byte not all ones");
    a_unit_holds: assert property (xfer_req_o && !xfer_done_i && !standby_i |=> xfer_req_o && $stable(xfer_src_o)
        && $stable(xfer_dst_o) && $stable(xfer_word_o))
        else $error("pending unit changed before completion");
    a_standby_clears: assert property (standby_i ##1 standby_i |=> !xfer_req_o && !bus_hold_o
        && !transfer_end_interrupt_o)
        else $error("standby left channel active");
    a_nmi_no_start: assert property (nmi_i |-> ##2 !$rose(xfer_req_o))
        else $error("unit started after nmi");
    a_end_irq_idle: assert property ($rose(transfer_end_interrupt_o) |-> !xfer_req_o)
        else $error("end interrupt while requesting");
endmodule
bind dfa_channel dfa_channel_checker dfa_channel_checker_inst (.core_clk_i, .resetn_i, .standby_i, .nmi_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .xfer_done_i, .xfer_req_o,
    .xfer_word_o, .xfer_src_o, .xfer_dst_o, .bus_hold_o, .transfer_end_interrupt_o);

// [tb/dfa_bus_model.sv]
// system bus model: completes each requested unit after a prompt or random delay
`timescale 1ns/10ps
module dfa_bus_model
(
    input wire core_clk_i,
    input wire resetn_i,
    input wire slow_i,
    input wire xfer_req_i,
    output reg xfer_done_o,
    output reg hp_req_o
);
    integer cnt;
    integer lat;
    always @(posedge core_clk_i)
    begin
        if (!resetn_i)
        begin
            xfer_done_o <= 1'b0;
            hp_req_o <= 1'b0;
            cnt <= 0;
            lat <= 1;
        end
        else
        begin
            xfer_done_o <= 1'b0;
            // a higher master grabs the bus now and then when stalling
            hp_req_o <= slow_i && ($urandom_range(7, 0) == 0);
            // never complete twice in a row: a dropping request must not be counted again
            if (xfer_req_i && !xfer_done_o)
            begin
                if (cnt >= lat)
                begin
                    xfer_done_o <= 1'b1;
                    cnt <= 0;
                    lat <= slow_i ? $urandom_range(4, 1) : 1;
                end
                else
                    cnt <= cnt + 1;
            end
        end
    end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the full-address dma channel with bus model and unit predictor
`timescale 1ns/10ps
`include "dfa_regs.vh"
module tb_top;
    reg core_clk_i, resetn_i, standby_i, nmi_i, psel_i, penable_i, pwrite_i, external_request_pin_n_i, slow;
    reg [11:0] paddr_i;
    reg [31:0] pwdata_i, rdat;
    reg [3:0] timer_match_i;
    reg rerr, sz, ie, blk;
    reg [1:0] sc, dc;
    reg [2:0] sel;
    wire [31:0] prdata_o;
    wire pready_o, pslverr_o, hp_req_i, xfer_done_i, xfer_req_o, xfer_word_o, bus_hold_o, transfer_end_interrupt_o;
    wire [23:0] xfer_src_o, xfer_dst_o;
    integer n_errors, samples_checked, i, n, bs, k, wt, rmode, exp_u;
    integer m_src, m_dst, m_ss, m_ds, m_units, m_bsz, m_in, m_area, m_base;
    localparam [11:0] o_src = `DFA_OFF_SRC_ADDR;
    localparam [11:0] o_pri = `DFA_OFF_CTL_PRI;
    localparam [11:0] o_sec = `DFA_OFF_CTL_SEC;
    dfa_channel dfa_channel_inst (.core_clk_i, .resetn_i, .standby_i, .nmi_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .external_request_pin_n_i, .timer_match_i,
        .hp_req_i, .xfer_done_i, .xfer_req_o, .xfer_word_o, .xfer_src_o, .xfer_dst_o, .bus_hold_o,
        .transfer_end_interrupt_o);
    dfa_bus_model dfa_bus_model_inst (.core_clk_i, .resetn_i, .slow_i(slow), .xfer_req_i(xfer_req_o),
        .xfer_done_o(xfer_done_i), .hp_req_o(hp_req_i));
    initial
    begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    task chk(input string what, input [63:0] exp, input [63:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            $display("BAD %0s exp %h got %h", what, exp, got);
            n_errors = n_errors + 1;
        end
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
    begin
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        @(posedge core_clk_i);
        while (pready_o !== 1'b1)
            @(posedge core_clk_i);
        rdat = prdata_o;
        rerr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    end
    endtask
    task rc(input [11:0] a, input [31:0] exp, input string what);
    begin
        apb(1'b0, a, 32'h00000000);
        chk(what, exp, rdat);
    end
    endtask
    // enable bits only take a one right after a read of the register
    task arm(input [11:0] a, input [31:0] v);
    begin
        apb(1'b0, a, 32'h00000000);
        apb(1'b1, a, v);
    end
    endtask
    task wait_units(input integer u);
    begin
        wt = 0;
        while (m_units < u && wt < 3000)
        begin
            @(posedge core_clk_i);
            wt = wt + 1;
        end
    end
    endtask
    task do_reset;
    begin
        resetn_i <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        resetn_i <= 1'b1;
    end
    endtask
    task summarize;
    begin
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    // request sources keep running after the count ends so ignored requests show up as extra units
    always @(posedge core_clk_i)
    begin
        external_request_pin_n_i <= (rmode == 2) ? 1'b0 : (rmode == 1) ? ~external_request_pin_n_i : 1'b1;
        timer_match_i <= (rmode == 3 && $urandom_range(3, 0) == 0) ? (4'h1 << $urandom_range(3, 0)) : 4'h0;
    end
    always @(posedge core_clk_i)
    begin
        if (resetn_i === 1'b1 && xfer_req_o === 1'b1 && xfer_done_i === 1'b1)
        begin
            chk("unit", {m_src[23:0], m_dst[23:0], sz}, {xfer_src_o, xfer_dst_o, xfer_word_o});
            m_src = m_src + m_ss;
            m_dst = m_dst + m_ds;
            m_units = m_units + 1;
            m_in = m_in + 1;
            if (m_bsz > 0 && m_in == m_bsz)
            begin
                m_in = 0;
                if (m_area == 1)
                    m_src = m_base;
                else
                    m_dst = m_base;
            end
        end
    end
    initial
    begin
        repeat (60000) @(posedge core_clk_i);
        n_errors = n_errors + 1;
        summarize;
    end
    initial
    begin
        {resetn_i, standby_i, nmi_i, psel_i, penable_i, pwrite_i, slow, sz} = 8'h00;
        {external_request_pin_n_i, paddr_i, pwdata_i, timer_match_i} = {1'b1, 12'h000, 32'h0, 4'h0};
        {n_errors, samples_checked, rmode, m_units, m_bsz, m_in} = 0;
        k = $urandom(3);
        do_reset;
        rc(o_pri, 0, "pri reset");
        rc(o_sec, 0, "sec reset");
        apb(1'b1, o_src, 32'h5AA5C3E1);
        apb(1'b1, `DFA_OFF_XFER_CNT, 32'h00001234);
        apb(1'b1, o_sec, 32'h00000040);
        rc(o_src, 32'hFFA5C3E1, "src top");
        rc(o_sec, 32'h00000040, "sec reserved");
        apb(1'b1, o_sec, 32'h00000040);
        apb(1'b1, o_sec, 32'h000000C0);
        rc(o_sec, 32'h00000040, "sec unarmed");
        apb(1'b1, o_pri, 32'h00000000);
        apb(1'b1, o_pri, 32'h00000080);
        rc(o_pri, 32'h00000000, "pri unarmed");
        apb(1'b0, 12'h018, 32'h0);
        chk("slverr", 1, rerr);
        apb(1'b1, o_pri, 32'h0000004E);
        standby_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        standby_i <= 1'b0;
        rc(o_pri, 0, "pri standby");
        rc(o_sec, 0, "sec standby");
        do_reset;
        rc(o_src, 32'hFFA5C3E1, "src kept");
        rc(`DFA_OFF_XFER_CNT, 32'h00001234, "cnt kept");
        $display("test registers done");
        for (i = 0; i < 6; i = i + 1)
        begin
            blk = (i >= 4);
            sz = $urandom_range(1, 0);
            sc = $urandom_range(3, 0);
            dc = $urandom_range(3, 0);
            ie = (i != 2);
            sel = blk ? $urandom_range(3, 0) : ((i == 0) ? 3'h0 : (i == 1) ? 3'h2 : (i == 2) ? 3'h6 : 3'h7);
            n = $urandom_range(6, 3);
            bs = blk ? $urandom_range(3, 1) : 0;
            exp_u = blk ? bs * n : n;
            slow <= i[0];
            m_src = $urandom;
            m_dst = $urandom;
            apb(1'b1, o_src, m_src);
            apb(1'b1, `DFA_OFF_DST_ADDR, m_dst);
            apb(1'b1, `DFA_OFF_XFER_CNT, blk ? {16'h0000, bs[7:0], bs[7:0]} : n);
            apb(1'b1, `DFA_OFF_BLK_CNT, n);
            m_ss = sc[0] ? (sc[1] ? -(sz + 1) : sz + 1) : 0;
            m_ds = dc[0] ? (dc[1] ? -(sz + 1) : sz + 1) : 0;
            m_area = $urandom_range(1, 0);
            m_src = m_src & 32'h00FFFFFF;
            m_dst = m_dst & 32'h00FFFFFF;
            m_base = (m_area == 1) ? m_src : m_dst;
            m_bsz = bs;
            m_in = 0;
            m_units = 0;
            rmode = blk ? 3 : (sel == 3'h6) ? 1 : (sel == 3'h7) ? 2 : 0;
            arm(o_sec, {24'h0, 2'b10, dc, m_area[0], sel});
            arm(o_pri, {24'h0, 1'b1, sz, sc, ie, 2'b11, blk});
            if (i == 1)
            begin
                wait_units(1);
                nmi_i <= 1'b1;
                @(posedge core_clk_i);
                nmi_i <= 1'b0;
                repeat (10) @(posedge core_clk_i);
                k = m_units;
                repeat (40) @(posedge core_clk_i);
                chk("nmi suspend", k, m_units);
                arm(o_sec, {24'h0, 2'b10, dc, m_area[0], sel});
            end
            wait_units(exp_u);
            repeat (40) @(posedge core_clk_i);
            chk("units", exp_u, m_units);
            chk("end irq", ie, transfer_end_interrupt_o);
            rc(o_pri, {24'h0, 1'b0, sz, sc, ie, 2'b11, blk}, "pri end");
            rmode = 0;
            $display("test channel %0d done", i);
        end
        summarize;
    end
endmodule
